//--- inc/asc_pkg.sv
// constants, types and register map of the active serial configuration master
// assumes a 20 MHz reference clock and a 32-bit apb register bus
package asc_pkg;

   // ----------------------------------------------------------------
   // clocking
   // ----------------------------------------------------------------
   localparam int unsigned REF_CLK_HZ = 20_000_000;
   localparam int unsigned DEFAULT_MAX_HZ = 40_000_000;
   localparam int unsigned SLOW_MAX_HZ = 20_000_000;
   localparam int unsigned FAST_MAX_HZ = 40_000_000;
   // two reference cycles per half period let the synchronised data settle
   localparam int unsigned MIN_HALF = 2;

   function automatic int unsigned half_cnt(input int unsigned f_hz);
      int unsigned h;
      h = (REF_CLK_HZ + 2 * f_hz - 1) / (2 * f_hz);
      return (h < MIN_HALF) ? MIN_HALF : h;
   endfunction

   localparam logic [7:0] HALF_DEFAULT = 8'(half_cnt(DEFAULT_MAX_HZ));
   localparam logic [7:0] HALF_SLOW = 8'(half_cnt(SLOW_MAX_HZ));
   localparam logic [7:0] HALF_FAST = 8'(half_cnt(FAST_MAX_HZ));

   // ----------------------------------------------------------------
   // stream layout
   // ----------------------------------------------------------------
   localparam logic [6:0] CMD_BITS = 7'h20;
   localparam logic [6:0] HDR_BITS = 7'h40;
   localparam logic [7:0] READ_CMD = 8'h03;
   localparam int CELL_AW = 8;
   localparam int LEN_W = 9;
   localparam int STRAP_W = 4;
   localparam logic [STRAP_W-1:0] MASTER_STRAP = 4'h2;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam int APB_AW = 8;
   localparam logic [APB_AW-1:0] REG_CTRL = 8'h00;
   localparam logic [APB_AW-1:0] REG_ADDR = 8'h04;
   localparam logic [APB_AW-1:0] REG_LEN = 8'h08;
   localparam logic [APB_AW-1:0] REG_STATUS = 8'h0C;
   localparam logic [APB_AW-1:0] REG_CELL_ADDR = 8'h10;
   localparam logic [APB_AW-1:0] REG_CELL_DATA = 8'h14;
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_FIELD_LSB = 1;
   localparam int CTRL_FIELD_MSB = 4;
   localparam logic [23:0] ADDR_RST = 24'h000000;
   localparam logic [LEN_W-1:0] LEN_RST = 9'h100;

   typedef enum logic [1:0] {
      SRC_SLOW = 2'h0,
      SRC_FAST = 2'h1,
      SRC_USER = 2'h2
   } clk_src_t;

   typedef struct packed {
      logic daisy;
      clk_src_t src;
      logic compress;
   } ctrl_t;

   localparam ctrl_t CTRL_RST = '{daisy: 1'b1, src: SRC_FAST, compress: 1'b0};

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_CMD = 3'h1,
      ST_HEADER = 3'h3,
      ST_DATA = 3'h2,
      ST_FWD = 3'h6,
      ST_INIT = 3'h7,
      ST_SLV_DATA = 3'h4
   } cfg_state_t;

   typedef struct packed {
      logic we;
      logic [CELL_AW-1:0] addr;
      logic [7:0] data;
   } cell_wr_t;

endpackage

//--- core/cfg_cell_mem.sv
// configuration cell store, one write port and one registered read port
// assumes both ports on ref_clk; the array itself is not reset
module cfg_cell_mem (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire asc_pkg::cell_wr_t wr,
   input wire logic [asc_pkg::CELL_AW-1:0] rd_addr,
   output logic [7:0] rd_data
);
   import asc_pkg::*;

   logic [7:0] cells [0:(1<<CELL_AW)-1];

   always_ff @(posedge ref_clk) begin
      if (wr.we) begin
         cells[wr.addr] <= wr.data;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= cells[rd_addr];
      end
   end

endmodule

//--- core/active_serial_config_master.sv
// active serial configuration master with passive-scheme slave fallback
// assumes pins are asynchronous to ref_clk; open-drain lines pulled up
//
// Local design decisions: the register addresses and the APB register port.
module active_serial_config_master (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [asc_pkg::APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serial_link_clock_i,
   output logic serial_link_clock_o,
   output logic serial_link_clock_oe,
   output logic flash_select_out_n,
   output logic cmd_serial_out,
   input wire logic config_serial_in,
   input wire logic user_clock_input,
   input wire logic [asc_pkg::STRAP_W-1:0] scheme_select_straps,
   input wire logic chain_enable_in_n,
   output logic chain_enable_out_n,
   input wire logic load_done_i,
   output logic load_done_o,
   output logic load_done_oe,
   input wire logic cfg_status_i,
   output logic cfg_status_o,
   output logic cfg_status_oe,
   output logic init_mode
);
   import asc_pkg::*;

   localparam int SYNC_W = STRAP_W + 6;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [SYNC_W-1:0] raw_in;
   logic [SYNC_W-1:0] meta_q;
   logic [SYNC_W-1:0] sync_q;
   logic s_sclk, s_data, s_usr, s_chain_n, s_done, s_stat;
   logic [STRAP_W-1:0] s_straps;
   logic sclk_prev_q, usr_prev_q;
   logic slv_rise, usr_rise;

   ctrl_t ctrl_q;
   logic [23:0] addr_q;
   logic [LEN_W-1:0] own_len_q;
   logic [CELL_AW-1:0] rd_addr_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic [31:0] rd_val;
   logic hit;
   logic setup, access, wr_ok, go;

   cfg_state_t state_q;
   logic passive_q;
   logic [6:0] bit_cnt_q;
   logic [7:0] div_cnt_q;
   logic [7:0] half;
   logic sclk_q;
   logic master_run, user_phase, toggle, fall;
   logic [31:0] cmd_sr_q;
   logic cmd_out_q;
   logic fsel_n_q;

   logic cap;
   logic [7:0] bsr_q;
   logic [2:0] bcnt_q;
   logic byte_rdy;
   logic [7:0] byte_val;
   logic comp;
   logic have_cnt_q, expanding_q;
   logic [7:0] rle_cnt_q, rle_val_q;
   logic [LEN_W-1:0] cell_cnt_q;
   logic own_done;
   cell_wr_t cell_wr;
   logic [7:0] cell_rd_data;
   logic chain_out_n_q, ld_oe_q, st_oe_q;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   assign raw_in = {scheme_select_straps, cfg_status_i, load_done_i,
                    chain_enable_in_n, user_clock_input, config_serial_in,
                    serial_link_clock_i};

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= raw_in;
         sync_q <= meta_q;
      end
   end

   assign s_sclk = sync_q[0];
   assign s_data = sync_q[1];
   assign s_usr = sync_q[2];
   assign s_chain_n = sync_q[3];
   assign s_done = sync_q[4];
   assign s_stat = sync_q[5];
   assign s_straps = sync_q[SYNC_W-1 -: STRAP_W];

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sclk_prev_q <= 1'b0;
         usr_prev_q <= 1'b0;
      end else begin
         sclk_prev_q <= s_sclk;
         usr_prev_q <= s_usr;
      end
   end

   assign slv_rise = s_sclk & ~sclk_prev_q;
   assign usr_rise = s_usr & ~usr_prev_q;

   // ----------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------
   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign wr_ok = access & pwrite & ~pslverr_q;
   // a start is refused unless this device's chain enable is low
   assign go = wr_ok && paddr == REG_CTRL && pwdata[CTRL_START_BIT] &&
               (state_q == ST_IDLE || state_q == ST_INIT) && !s_chain_n;

   always_comb begin
      rd_val = 32'h00000000;
      hit = 1'b1;
      case (paddr)
         REG_CTRL: rd_val = {27'h0000000, ctrl_q, 1'b0};
         REG_ADDR: rd_val = {8'h00, addr_q};
         REG_LEN: rd_val = {23'h000000, own_len_q};
         REG_STATUS: rd_val = {7'h00, cell_cnt_q, 8'h00, s_chain_n, s_stat,
                               s_done, own_done, passive_q, state_q};
         REG_CELL_ADDR: rd_val = {24'h000000, rd_addr_q};
         REG_CELL_DATA: rd_val = {24'h000000, cell_rd_data};
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         prdata_q <= 32'h00000000;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         prdata_q <= pwrite ? 32'h00000000 : rd_val;
         pslverr_q <= ~hit;
      end
   end

   assign prdata = prdata_q;
   assign pslverr = pslverr_q;
   assign pready = penable;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= CTRL_RST;
         addr_q <= ADDR_RST;
         own_len_q <= LEN_RST;
         rd_addr_q <= '0;
      end else if (wr_ok) begin
         case (paddr)
            REG_CTRL: ctrl_q <= pwdata[CTRL_FIELD_MSB:CTRL_FIELD_LSB];
            REG_ADDR: addr_q <= pwdata[23:0];
            REG_LEN: own_len_q <= pwdata[LEN_W-1:0];
            REG_CELL_ADDR: rd_addr_q <= pwdata[CELL_AW-1:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // role strap
   // ----------------------------------------------------------------
   // straps are sampled only while idle, never at the reset edge
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         passive_q <= 1'b0;
      end else if (state_q == ST_IDLE) begin
         passive_q <= (s_straps != MASTER_STRAP);
      end
   end

   // ----------------------------------------------------------------
   // link clock generation
   // ----------------------------------------------------------------
   // in concurrent mode the clock stops once this device is loaded,
   // since every slave takes exactly the same stream
   assign master_run = !passive_q &&
                       (state_q == ST_CMD || state_q == ST_HEADER ||
                        state_q == ST_DATA ||
                        (state_q == ST_FWD && ctrl_q.daisy));
   assign user_phase = ctrl_q.src == SRC_USER &&
                       (state_q == ST_DATA || state_q == ST_FWD);

   always_comb begin
      half = HALF_DEFAULT;
      if (state_q == ST_DATA || state_q == ST_FWD) begin
         half = (ctrl_q.src == SRC_SLOW) ? HALF_SLOW : HALF_FAST;
      end
   end

   // user clock is seen through the synchroniser, so the link runs at
   // half its rate at best; a limit of sampling with ref_clk
   assign toggle = master_run && !expanding_q && (user_phase ?
                   usr_rise && |div_cnt_q : div_cnt_q == half - 8'h01);
   assign fall = toggle & sclk_q;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         div_cnt_q <= 8'h00;
      end else if (!master_run || toggle) begin
         div_cnt_q <= 8'h00;
      end else if (!expanding_q) begin
         div_cnt_q <= div_cnt_q + 8'h01;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sclk_q <= 1'b1;
      end else if (state_q == ST_IDLE || state_q == ST_INIT) begin
         sclk_q <= 1'b1;
      end else if (toggle) begin
         sclk_q <= ~sclk_q;
      end
   end

   assign serial_link_clock_o = sclk_q;
   assign serial_link_clock_oe = ~passive_q;

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= ST_IDLE;
         bit_cnt_q <= 7'h00;
      end else begin
         case (state_q)
            ST_IDLE, ST_INIT: begin
               if (go) begin
                  state_q <= passive_q ? ST_SLV_DATA : ST_CMD;
                  bit_cnt_q <= 7'h00;
               end
            end
            ST_CMD: begin
               if (fall) begin
                  if (bit_cnt_q == CMD_BITS) begin
                     state_q <= ST_HEADER;
                     bit_cnt_q <= 7'h00;
                  end else begin
                     bit_cnt_q <= bit_cnt_q + 7'h01;
                  end
               end
            end
            ST_HEADER: begin
               if (fall) begin
                  if (bit_cnt_q == HDR_BITS - 7'h01) begin
                     state_q <= ST_DATA;
                     bit_cnt_q <= 7'h00;
                  end else begin
                     bit_cnt_q <= bit_cnt_q + 7'h01;
                  end
               end
            end
            ST_DATA, ST_SLV_DATA: begin
               if (own_done) begin
                  state_q <= ST_FWD;
               end
            end
            ST_FWD: begin
               if (s_done) begin
                  state_q <= ST_INIT;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   assign init_mode = (state_q == ST_INIT);

   // ----------------------------------------------------------------
   // command out and flash select
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cmd_sr_q <= 32'h00000000;
         cmd_out_q <= 1'b0;
      end else if (go) begin
         cmd_sr_q <= {READ_CMD, addr_q};
      end else if (state_q == ST_CMD && fall) begin
         if (bit_cnt_q < CMD_BITS) begin
            cmd_out_q <= cmd_sr_q[31];
            cmd_sr_q <= {cmd_sr_q[30:0], 1'b0};
         end else begin
            cmd_out_q <= 1'b0;
         end
      end
   end

   assign cmd_serial_out = cmd_out_q;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         fsel_n_q <= 1'b1;
      end else if (state_q == ST_CMD && fall && bit_cnt_q == 7'h00) begin
         fsel_n_q <= 1'b0;
      end else if ((state_q == ST_DATA && own_done && !ctrl_q.daisy) ||
                   (state_q == ST_FWD && s_done) ||
                   state_q == ST_IDLE || state_q == ST_INIT) begin
         fsel_n_q <= 1'b1;
      end
   end

   assign flash_select_out_n = fsel_n_q;

   // ----------------------------------------------------------------
   // bit capture and byte assembly
   // ----------------------------------------------------------------
   // memory launches on a fall, this side takes it one fall later
   assign cap = (state_q == ST_DATA && fall) ||
                (state_q == ST_SLV_DATA && slv_rise);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         bsr_q <= 8'h00;
         bcnt_q <= 3'h0;
      end else if (go) begin
         bcnt_q <= 3'h0;
      end else if (cap) begin
         bsr_q <= {s_data, bsr_q[7:1]};
         bcnt_q <= bcnt_q + 3'h1;
      end
   end

   assign byte_rdy = cap && bcnt_q == 3'h7;
   assign byte_val = {s_data, bsr_q[7:1]};

   // ----------------------------------------------------------------
   // decompression
   // ----------------------------------------------------------------
   // run-length pairs: count byte n, then value written n+1 times; the
   // link clock is held while expanding, so a passive slave cannot
   // throttle its sender and loads raw data instead
   assign comp = ctrl_q.compress & ~passive_q;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         have_cnt_q <= 1'b0;
         expanding_q <= 1'b0;
         rle_cnt_q <= 8'h00;
         rle_val_q <= 8'h00;
      end else if (go) begin
         have_cnt_q <= 1'b0;
         expanding_q <= 1'b0;
      end else if (expanding_q) begin
         if (rle_cnt_q == 8'h00 || own_done) begin
            expanding_q <= 1'b0;
         end else begin
            rle_cnt_q <= rle_cnt_q - 8'h01;
         end
      end else if (byte_rdy && comp && !own_done) begin
         if (!have_cnt_q) begin
            rle_cnt_q <= byte_val;
            have_cnt_q <= 1'b1;
         end else begin
            rle_val_q <= byte_val;
            expanding_q <= 1'b1;
            have_cnt_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // configuration cells
   // ----------------------------------------------------------------
   assign own_done = (cell_cnt_q == own_len_q);
   assign cell_wr.we = !own_done && (expanding_q || (byte_rdy && !comp));
   assign cell_wr.addr = cell_cnt_q[CELL_AW-1:0];
   assign cell_wr.data = expanding_q ? rle_val_q : byte_val;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cell_cnt_q <= '0;
      end else if (go) begin
         cell_cnt_q <= '0;
      end else if (cell_wr.we) begin
         cell_cnt_q <= cell_cnt_q + 9'h001;
      end
   end

   cfg_cell_mem u_cells (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .wr(cell_wr),
      .rd_addr(rd_addr_q),
      .rd_data(cell_rd_data)
   );

   // ----------------------------------------------------------------
   // chain and shared open-drain lines
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         chain_out_n_q <= 1'b1;
         ld_oe_q <= 1'b1;
         st_oe_q <= 1'b1;
      end else if (go) begin
         chain_out_n_q <= 1'b1;
         ld_oe_q <= 1'b1;
         st_oe_q <= 1'b0;
      end else if (own_done &&
                   (state_q == ST_DATA || state_q == ST_SLV_DATA)) begin
         chain_out_n_q <= 1'b0;
         ld_oe_q <= 1'b0;
      end
   end

   assign chain_enable_out_n = chain_out_n_q;
   assign load_done_o = 1'b0;
   assign load_done_oe = ld_oe_q;
   assign cfg_status_o = 1'b0;
   assign cfg_status_oe = st_oe_q;

endmodule

//--- testbench/asc_props.sv
// pin checker for the configuration master
// assumes a bind onto the top module; one clock domain
module asc_props (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic serial_link_clock_o,
   input wire logic serial_link_clock_oe,
   input wire logic flash_select_out_n,
   input wire logic cmd_serial_out,
   input wire logic chain_enable_out_n,
   input wire logic load_done_i,
   input wire logic load_done_oe,
   input wire logic init_mode
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // ------------------------------------------------------------
   // link and line relations
   // ------------------------------------------------------------
   property p_cmd_fall;
      !flash_select_out_n && $changed(cmd_serial_out)
         |-> $fell(serial_link_clock_o);
   endproperty
   a_cmd_fall: assert property (p_cmd_fall)
      else $error("command bit moved off a link clock fall");
   property p_sel_fall;
      $fell(flash_select_out_n) |-> $fell(serial_link_clock_o);
   endproperty
   a_sel_fall: assert property (p_sel_fall)
      else $error("select fell off a link clock fall");
   property p_first_cmd;
      $fell(flash_select_out_n) |-> !cmd_serial_out;
   endproperty
   a_first_cmd: assert property (p_first_cmd)
      else $error("first command bit not zero");
   // the divider never toggles on two edges in a row while selected
   property p_half;
      !flash_select_out_n && $changed(serial_link_clock_o)
         |=> flash_select_out_n || $stable(serial_link_clock_o);
   endproperty
   a_half: assert property (p_half)
      else $error("link clock half period too short");
   property p_sel_drive;
      !flash_select_out_n |-> serial_link_clock_oe;
   endproperty
   a_sel_drive: assert property (p_sel_drive)
      else $error("flash selected without driving the clock");
   property p_release;
      !chain_enable_out_n |-> !load_done_oe;
   endproperty
   a_release: assert property (p_release)
      else $error("load-done still pulled after chain enable");
   property p_hold;
      $fell(load_done_oe) |-> $fell(chain_enable_out_n);
   endproperty
   a_hold: assert property (p_hold)
      else $error("load-done released before own data");
   property p_init_line;
      $rose(init_mode) |-> $past(load_done_i) && $past(load_done_i, 2);
   endproperty
   a_init_line: assert property (p_init_line)
      else $error("init entered without load-done high");
   property p_init_soon;
      (!chain_enable_out_n && load_done_i) [*6] |-> init_mode;
   endproperty
   a_init_soon: assert property (p_init_soon)
      else $error("init not entered after load-done rose");
   property p_init_sel;
      init_mode |-> flash_select_out_n;
   endproperty
   a_init_sel: assert property (p_init_sel)
      else $error("flash still selected in init");
   c_sel: cover property ($fell(flash_select_out_n));
   c_chain: cover property ($fell(chain_enable_out_n));
   c_init: cover property ($rose(init_mode));
endmodule

//--- testbench/flash_model.sv
// serial flash model: takes a 32-bit read command, streams bytes
// assumes link clock idles high and select is active low
module flash_model (
   input wire logic sck,
   input wire logic sel_n,
   input wire logic din,
   output logic dout
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [256];
   logic [31:0] cmd;
   logic [7:0] a;
   int n;
   initial begin
      dout = 1'b0;
      cmd = '0;
      n = 0;
      for (int i = 0; i < 256; i++)
         mem[i] = 8'(i) ^ 8'h5A;
   end
   // released line shows a changing pattern, not the last bit
   always @(posedge sck or posedge sel_n) begin
      if (sel_n) begin
         n = 0;
         dout = ~dout;
      end else begin
         if (n < 32)
            cmd = {cmd[30:0], din};
         n = n + 1;
      end
   end
   // one memory only: the address runs on
   always @(negedge sck) begin
      if (!sel_n && n >= 32) begin
         a = cmd[7:0] + 8'((n - 32) / 8);
         dout = mem[a][(n - 32) % 8];
      end
   end
endmodule

//--- testbench/active_serial_config_master_bench.sv
// bench: apb tasks, flash model, pulled-up shared lines
// assumes asc_pkg compiled first; the checker is bound below
module active_serial_config_master_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import asc_pkg::*;
   logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic sck_o, sck_oe, sel_n, cmd_o, user_clk, ce_in_n, ce_out_n;
   logic ld_o, ld_oe, st_o, st_oe, init_mode, fl_dout, pclk, pdata;
   logic other_low, use_flash;
   logic [STRAP_W-1:0] straps;
   int bad_count, total_checks;
   wire sck_pin = sck_oe ? sck_o : pclk;
   wire ld_pin = (ld_oe ? ld_o : 1'b1) & ~other_low;
   wire st_pin = st_oe ? st_o : 1'b1;
   wire cfg_in = use_flash ? fl_dout : pdata;
   active_serial_config_master dut_u (.ref_clk(ref_clk), .nrst(nrst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serial_link_clock_i(sck_pin),
      .serial_link_clock_o(sck_o), .serial_link_clock_oe(sck_oe),
      .flash_select_out_n(sel_n), .cmd_serial_out(cmd_o),
      .config_serial_in(cfg_in), .user_clock_input(user_clk),
      .scheme_select_straps(straps), .chain_enable_in_n(ce_in_n),
      .chain_enable_out_n(ce_out_n), .load_done_i(ld_pin),
      .load_done_o(ld_o), .load_done_oe(ld_oe), .cfg_status_i(st_pin),
      .cfg_status_o(st_o), .cfg_status_oe(st_oe), .init_mode(init_mode));
   flash_model flash_u (.sck(sck_o), .sel_n(sel_n), .din(cmd_o),
      .dout(fl_dout));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         bad_count++;
         report_and_stop;
      end
   endtask
   task automatic do_reset;
      nrst <= 1'b0;
      repeat (20) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (5) @(posedge ref_clk);
   endtask
   // polls own-done; the held shared line keeps init off
   task automatic wait_done(input logic [31:0] cnt);
      int n;
      n = 0;
      do begin
         apb(1'b0, REG_STATUS, '0);
         n++;
      end while (rd[4] !== 1'b1 && n < 3000);
      check(rd[4], 1'b1);
      if (rd[4] !== 1'b1)
         report_and_stop;
      check(rd[24:16], cnt);
      check({ce_out_n, ld_oe}, 2'b00);
      check(init_mode, 1'b0);
   endtask
   task automatic wait_init;
      other_low <= 1'b0;
      for (int i = 0; i < 40 && init_mode !== 1'b1; i++)
         @(posedge ref_clk);
      check(init_mode, 1'b1);
      if (init_mode !== 1'b1)
         report_and_stop;
      check(sel_n, 1'b1);
   endtask
   task automatic cells(input int cnt, input logic [31:0] exp);
      for (int k = 0; k < cnt; k++) begin
         apb(1'b1, REG_CELL_ADDR, 32'(k));
         repeat (2) @(posedge ref_clk);
         apb(1'b0, REG_CELL_DATA, '0);
         check(rd, {24'h0, exp[8*k+:8]});
      end
   endtask
   task automatic run_master(input logic [31:0] ctl, input logic [23:0] adr,
                             input logic [31:0] exp);
      other_low <= 1'b1;
      apb(1'b1, REG_ADDR, {8'h00, adr});
      apb(1'b1, REG_CTRL, ctl);
      wait_done(32'h4);
      check(flash_u.cmd, {READ_CMD, adr});
      check(sel_n, !ctl[4]);
      wait_init;
      cells(4, exp);
      $display("test master ctrl %h done", ctl);
   endtask
   task automatic send_slv(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         pclk <= 1'b0;
         pdata <= b[i];
         repeat (4) @(posedge ref_clk);
         pclk <= 1'b1;
         repeat (4) @(posedge ref_clk);
      end
   endtask
   // ------------------------------------------------------------
   // clocks and sequence
   // ------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   // offset keeps user clock edges off the reference edges
   initial begin
      user_clk = 1'b0;
      #1;
      forever #55 user_clk = ~user_clk;
   end
   initial begin
      nrst = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      straps = MASTER_STRAP;
      ce_in_n = 1'b0;
      {pclk, pdata, other_low, use_flash} = 4'hB;
      bad_count = 0;
      total_checks = 0;
      do_reset;
      check({sel_n, ce_out_n, ld_oe, st_oe, init_mode}, 5'h1E);
      apb(1'b0, REG_CTRL, '0);
      check(rd, 32'h14);
      apb(1'b0, REG_LEN, '0);
      check(rd, 32'h100);
      apb(1'b0, 8'h18, '0);
      check({rd[30:0], err}, 32'h1);
      ce_in_n <= 1'b1;
      repeat (4) @(posedge ref_clk);
      apb(1'b1, REG_CTRL, 32'h15);
      apb(1'b0, REG_STATUS, '0);
      check(rd[3:0], 4'h0);
      ce_in_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      apb(1'b1, REG_LEN, 32'h4);
      $display("test reset and refusal done");
      run_master(32'h15, 24'h000020, 32'h71707372);
      flash_u.mem[8'h48] = 8'h01;
      flash_u.mem[8'h49] = 8'hA5;
      flash_u.mem[8'h4A] = 8'h01;
      flash_u.mem[8'h4B] = 8'h3C;
      run_master(32'h03, 24'h000040, 32'h3C3CA5A5);
      run_master(32'h19, 24'h000060, 32'h31303332);
      straps <= 4'h0;
      use_flash <= 1'b0;
      other_low <= 1'b1;
      do_reset;
      apb(1'b0, REG_STATUS, '0);
      check({rd[3], sck_oe}, 2'b10);
      apb(1'b1, REG_LEN, 32'h2);
      apb(1'b1, REG_CTRL, 32'h11);
      send_slv(8'hC3);
      send_slv(8'h5E);
      pdata <= ~pdata;
      wait_done(32'h2);
      wait_init;
      cells(2, 32'h00005EC3);
      $display("test passive done");
      report_and_stop;
   end
endmodule
bind active_serial_config_master asc_props props_u (.ref_clk(ref_clk),
   .nrst(nrst), .serial_link_clock_o(serial_link_clock_o),
   .serial_link_clock_oe(serial_link_clock_oe),
   .flash_select_out_n(flash_select_out_n),
   .cmd_serial_out(cmd_serial_out),
   .chain_enable_out_n(chain_enable_out_n), .load_done_i(load_done_i),
   .load_done_oe(load_done_oe), .init_mode(init_mode));
